// File: core/ofhp_host_port.sv
////////////////////////////////////////////////////////////////////////////////
module ofhp_host_port #(
   parameter int DATA_W = ofhp_pkg::DATA_W,
   parameter int ADDR_W = ofhp_pkg::ADDR_W,
   parameter int NUM_FRAMERS = ofhp_pkg::NUM_FRAMERS
) (
   input wire logic clock_i,                              // 50 MHz clock
   input wire logic resetn_i,                             // Sync reset, active low
   input wire logic [ADDR_W-1:0] host_addr_bus_i,         // Host address
   input wire logic [DATA_W-1:0] host_data_bus_i,         // Data bus input level
   output logic [DATA_W-1:0] host_data_bus_o,             // Data bus drive value
   output logic host_data_bus_oe_o,                       // High while driving bus
   input wire logic chip_select_n_i,                      // Chip select, active low
   input wire logic bus_style_sel_i,                      // 1 separate, 0 single strobe
   input wire logic single_data_strobe_n_i,               // Data strobe or read strobe
   input wire logic rw_dir_i,                             // Direction or write strobe
   output logic host_irq_n_o,                             // Open-drain level, always 0
   output logic host_irq_oe_o,                            // High while pulling low
   input wire logic ext_reset_n_i,                        // Device reset pin
   input wire logic force_alarm_all_ones_n_i,             // Alarm force pin
   input wire logic [NUM_FRAMERS-1:0] framer_irq_req_i,   // Pending requests
   input wire logic [DATA_W-1:0] framer_rdata_i,          // Read data, same cycle as rd
   output ofhp_pkg::ofhp_access_s framer_acc_o,           // Access target and data
   output logic framer_rd_o,                              // Read pulse
   output logic framer_wr_o,                              // Write pulse
   output logic framer_reset_o,                           // Framer reset, active high
   output logic [NUM_FRAMERS-1:0] alarm_all_ones_pattern_o // Per-framer all-ones force
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode, shared by reads and writes
   function automatic ofhp_pkg::ofhp_target_s decode_addr(input logic [ADDR_W-1:0] a,
                                                           input logic is_write);
      ofhp_pkg::ofhp_target_s t;
      logic [ofhp_pkg::SEL_W-1:0] sel;
      t = '0;
      sel = a[ofhp_pkg::SEL_LSB +: ofhp_pkg::SEL_W];
      t.offset = a[ofhp_pkg::OFFSET_W-1:0];
      if (a[ofhp_pkg::BCAST_BIT] && a[ofhp_pkg::GLB_HIGH_BIT] && !a[ofhp_pkg::GLB_LOW_BIT]) begin
         t.global_sel = 1'b1;
      end else if (a[ofhp_pkg::BCAST_BIT] && sel == '0 && is_write) begin
         t.bcast = 1'b1;
         t.framer_mask = '1;
      end else begin
         t.framer_mask = NUM_FRAMERS'(1) << sel;
      end
      return t;
   endfunction : decode_addr

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for asynchronous pins
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] sync_in;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   assign sync_in = {force_alarm_all_ones_n_i, ext_reset_n_i, rw_dir_i,
                     single_data_strobe_n_i, chip_select_n_i};

   // First stage feeds only the second stage
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         sync1_reg <= 5'h1F;
         sync2_reg <= 5'h1F;
      end else begin
         sync1_reg <= sync_in;
         sync2_reg <= sync1_reg;
      end
   end

   logic cs_n_s, strb_a_n_s, strb_b_s, ext_rst_n_s, alarm_n_s;
   assign cs_n_s = sync2_reg[0];
   assign strb_a_n_s = sync2_reg[1];
   assign strb_b_s = sync2_reg[2];
   assign ext_rst_n_s = sync2_reg[3];
   assign alarm_n_s = sync2_reg[4];

   ////////////////////////////////////////////////////////////////////////////
   // Strobe qualification; select gates every strobe so a tied strobe works
   logic rd_act, wr_act, rd_act_reg, wr_act_reg;
   logic rd_fall, wr_fall, wr_rise;
   always_comb begin
      if (bus_style_sel_i) begin
         rd_act = !cs_n_s && !strb_a_n_s;
         wr_act = !cs_n_s && !strb_b_s;
      end else begin
         rd_act = !cs_n_s && !strb_a_n_s && strb_b_s;
         wr_act = !cs_n_s && !strb_a_n_s && !strb_b_s;
      end
   end
   assign rd_fall = rd_act && !rd_act_reg;
   assign wr_fall = wr_act && !wr_act_reg;
   assign wr_rise = !wr_act && wr_act_reg;

   // Previous strobe levels for edge detection
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         rd_act_reg <= 1'b0;
         wr_act_reg <= 1'b0;
      end else begin
         rd_act_reg <= rd_act;
         wr_act_reg <= wr_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access sequencer
   ofhp_pkg::ofhp_state_e state_reg, state_next;
   logic access_ok;
   assign access_ok = ext_rst_n_s;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ofhp_pkg::ST_IDLE: begin
            if (!access_ok) begin
               state_next = ofhp_pkg::ST_IDLE;
            end else if (rd_fall) begin
               state_next = ofhp_pkg::ST_RD_WAIT;
            end else if (wr_fall && bus_style_sel_i) begin
               state_next = ofhp_pkg::ST_WR_HOLD;
            end
         end
         ofhp_pkg::ST_RD_WAIT: begin
            state_next = rd_act ? ofhp_pkg::ST_RD_DRIVE : ofhp_pkg::ST_IDLE;
         end
         ofhp_pkg::ST_RD_DRIVE: begin
            if (!rd_act) begin
               state_next = ofhp_pkg::ST_IDLE;
            end
         end
         ofhp_pkg::ST_WR_HOLD: begin
            if (!wr_act || !access_ok) begin
               state_next = ofhp_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         state_reg <= ofhp_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address latch and framer access strobes
   logic [ADDR_W-1:0] addr_reg;
   logic wr_issue;
   // Single style writes on the fall; separate style on the write rise
   assign wr_issue = access_ok && (bus_style_sel_i
                                   ? (state_reg == ofhp_pkg::ST_WR_HOLD && wr_rise)
                                   : (state_reg == ofhp_pkg::ST_IDLE && wr_fall));

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         addr_reg <= '0;
      end else if (state_reg == ofhp_pkg::ST_IDLE && (rd_fall || wr_fall)) begin
         addr_reg <= host_addr_bus_i;
      end
   end

   // Access record and one-cycle pulses to the framers
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         framer_acc_o <= '0;
         framer_rd_o <= 1'b0;
         framer_wr_o <= 1'b0;
      end else begin
         framer_rd_o <= 1'b0;
         framer_wr_o <= 1'b0;
         if (state_reg == ofhp_pkg::ST_IDLE && rd_fall && access_ok) begin
            framer_acc_o.target <= decode_addr(host_addr_bus_i, 1'b0);
            framer_rd_o <= 1'b1;
         end else if (wr_issue) begin
            framer_acc_o.target <= decode_addr(bus_style_sel_i ? addr_reg : host_addr_bus_i,
                                               1'b1);
            framer_acc_o.wdata <= host_data_bus_i;
            framer_wr_o <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data and bus drive
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         host_data_bus_o <= ofhp_pkg::DATA_RST;
      end else if (state_reg == ofhp_pkg::ST_RD_WAIT) begin
         host_data_bus_o <= framer_rdata_i;
      end
   end

   // Drive only during an active read with select low
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         host_data_bus_oe_o <= 1'b0;
      end else begin
         host_data_bus_oe_o <= rd_act
                               && (state_next == ofhp_pkg::ST_RD_DRIVE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt, reset and alarm outputs
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         host_irq_n_o <= 1'b0;
         host_irq_oe_o <= 1'b0;
      end else begin
         host_irq_n_o <= 1'b0;
         host_irq_oe_o <= |framer_irq_req_i;
      end
   end

   // Framer reset follows the synchronised reset pin
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         framer_reset_o <= 1'b1;
      end else begin
         framer_reset_o <= !ext_rst_n_s;
      end
   end

   // All-ones force to every framer transmitter
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         alarm_all_ones_pattern_o <= ofhp_pkg::MASK_RST;
      end else begin
         alarm_all_ones_pattern_o <= {NUM_FRAMERS{!alarm_n_s}};
      end
   end

endmodule : ofhp_host_port

// File: core/ofhp_pkg.sv
package ofhp_pkg;
   // Bus widths and framer count
   localparam int DATA_W = 16;
   localparam int ADDR_W = 12;
   localparam int NUM_FRAMERS = 8;
   localparam int OFFSET_W = 8;
   localparam int SEL_W = 3;

   // Address field positions
   localparam int SEL_LSB = 8;
   localparam int ID_MSB = 11;
   localparam int BCAST_BIT = 11;
   localparam int GLB_LOW_BIT = 9;
   localparam int GLB_HIGH_BIT = 8;

   // Synchroniser depth
   localparam int SYNC_STAGES = 2;

   // Reset values
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [NUM_FRAMERS-1:0] MASK_RST = 8'h00;

   // Timing: minimum external reset width and its cycle count
   localparam int CLK_PERIOD_NS = 20;
   localparam int RESET_MIN_NS = 100;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Access target decoded from the address: upper field selects, low field is offset
   typedef struct packed {
      logic [NUM_FRAMERS-1:0] framer_mask; // One bit per framer
      logic global_sel;                    // Global control registers
      logic bcast;                         // All framers at once
      logic [OFFSET_W-1:0] offset;         // Per-framer register offset
   } ofhp_target_s;

   // Register access passed to the framer cores
   typedef struct packed {
      ofhp_target_s target;
      logic [DATA_W-1:0] wdata;
   } ofhp_access_s;

   // Access sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RD_WAIT = 2'b01,
      ST_RD_DRIVE = 2'b10,
      ST_WR_HOLD = 2'b11
   } ofhp_state_e;
endpackage : ofhp_pkg

// File: tb/ofhp_checker.sv
module ofhp_checker (
   input wire logic clock_i, // Clock
   input wire logic resetn_i, // Sync reset
   input wire logic chip_select_n_i, // Select
   input wire logic force_alarm_all_ones_n_i, // Alarm pin
   input wire logic ext_reset_n_i, // Reset pin
   input wire logic [7:0] framer_irq_req_i, // Requests
   input wire logic [15:0] framer_rdata_i, // Read data
   input wire logic [15:0] host_data_bus_o, // Drive value
   input wire logic host_data_bus_oe_o, // Drive enable
   input wire logic host_irq_n_o, // Irq level
   input wire logic host_irq_oe_o, // Irq enable
   input wire ofhp_pkg::ofhp_access_s framer_acc_o, // Access
   input wire logic framer_rd_o, // Read pulse
   input wire logic framer_wr_o, // Write pulse
   input wire logic framer_reset_o, // Framer reset
   input wire logic [7:0] alarm_all_ones_pattern_o // Alarm out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt and bus
   chk_irq_follow: assert property ((|framer_irq_req_i)
      |=> host_irq_oe_o && !host_irq_n_o) else $error("irq not pulled");
   chk_irq_release: assert property (!(|framer_irq_req_i) |=> !host_irq_oe_o)
      else $error("irq not released");
   chk_cs_float: assert property (chip_select_n_i [*5] |-> !host_data_bus_oe_o)
      else $error("bus driven while deselected");
   chk_read_drive: assert property ($rose(host_data_bus_oe_o) |-> $past(framer_rd_o)
      && host_data_bus_o == $past(framer_rdata_i)) else $error("read data wrong");
   chk_pulse_single: assert property ((framer_rd_o || framer_wr_o)
      |=> !(framer_rd_o || framer_wr_o)) else $error("pulse too long");
   chk_bcast_all: assert property (framer_wr_o && framer_acc_o.target.bcast
      |-> framer_acc_o.target.framer_mask == 8'hFF) else $error("broadcast mask");
   chk_global_none: assert property ((framer_rd_o || framer_wr_o)
      && framer_acc_o.target.global_sel |-> framer_acc_o.target.framer_mask == 8'h00)
      else $error("global mask");
   ////////////////////////////////////////////////////////////////////////////////
   // Device pins
   chk_alarm_force: assert property (!force_alarm_all_ones_n_i [*4]
      |-> alarm_all_ones_pattern_o == 8'hFF) else $error("alarm not forced");
   chk_alarm_free: assert property (force_alarm_all_ones_n_i [*4]
      |-> alarm_all_ones_pattern_o == 8'h00) else $error("alarm stuck");
   chk_reset_hold: assert property (!ext_reset_n_i [*4] |-> framer_reset_o)
      else $error("framers not in reset");
endmodule : ofhp_checker

bind ofhp_host_port ofhp_checker u_chk (.*);

// File: tb/ofhp_host_model.sv
module ofhp_host_model (
   input wire logic clock_i, // Clock
   input wire logic [15:0] wire_i, // Data wire level
   output logic style_o, // Bus style
   output logic cs_n_o, // Select
   output logic strobe_n_o, // Data or read strobe
   output logic dir_o, // Direction or write strobe
   output logic [11:0] addr_o, // Address
   output logic [15:0] wdata_o, // Data value
   output logic drive_o // Data drive enable
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus
   initial begin
      {style_o, cs_n_o, strobe_n_o, dir_o} = 4'hF;
      addr_o = 12'h000;
      wdata_o = 16'h0000;
      drive_o = 1'b0;
   end
   // One host cycle, strobe 8 cycles low then 6 high
   task automatic access(input logic sty, input logic rd, input logic [11:0] a,
      input logic [15:0] wd, input logic sel_n, output logic [15:0] rv);
      @(posedge clock_i);
      style_o <= sty;
      addr_o <= a;
      wdata_o <= wd;
      drive_o <= !rd;
      dir_o <= sty | rd;
      @(posedge clock_i);
      cs_n_o <= sel_n; // Select falls with strobe, rises six cycles after it
      if (sty && !rd) dir_o <= 1'b0;
      else strobe_n_o <= 1'b0;
      repeat (8) @(posedge clock_i);
      rv = wire_i;
      strobe_n_o <= 1'b1;
      dir_o <= sty | rd;
      repeat (6) @(posedge clock_i);
      cs_n_o <= 1'b1;
      drive_o <= 1'b0;
      repeat (4) @(posedge clock_i);
   endtask : access
endmodule : ofhp_host_model

// File: tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic ext_n = 1'b0; // Low through power-up
   logic alarm_n = 1'b0; // Low through power-up
   logic [7:0] irq_req = 8'h00;
   logic [15:0] d_o, wd, wire_v, rv, frd;
   logic oe, irq_n, irq_oe, rd_p, wr_p, frst, style, cs_n, stb_n, dir, drv;
   logic [11:0] addr;
   logic [7:0] alarm;
   ofhp_pkg::ofhp_access_s acc, seen;
   int bad_count = 0, checks = 0, cycles = 0, rd_cnt = 0, wr_cnt = 0;
   always #10 clock_i = ~clock_i;
   // Wire level; released wire shows inverse of host data value wd
   assign wire_v = oe ? d_o : (drv ? wd : ~wd);
   // Framer read data from offset
   assign frd = {8'hA5, acc.target.offset};
   ofhp_host_model u_host (.clock_i(clock_i), .wire_i(wire_v), .style_o(style), .cs_n_o(cs_n),
      .strobe_n_o(stb_n), .dir_o(dir), .addr_o(addr), .wdata_o(wd), .drive_o(drv));
   ofhp_host_port u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .host_addr_bus_i(addr),
      .host_data_bus_i(wire_v), .host_data_bus_o(d_o), .host_data_bus_oe_o(oe),
      .chip_select_n_i(cs_n), .bus_style_sel_i(style), .single_data_strobe_n_i(stb_n),
      .rw_dir_i(dir), .host_irq_n_o(irq_n), .host_irq_oe_o(irq_oe), .ext_reset_n_i(ext_n),
      .force_alarm_all_ones_n_i(alarm_n), .framer_irq_req_i(irq_req), .framer_rdata_i(frd),
      .framer_acc_o(acc), .framer_rd_o(rd_p), .framer_wr_o(wr_p), .framer_reset_o(frst),
      .alarm_all_ones_pattern_o(alarm));
   // Pulse monitor and timeout
   always @(posedge clock_i) begin
      cycles++;
      if (rd_p || wr_p) seen <= acc;
      rd_cnt <= rd_cnt + rd_p;
      wr_cnt <= wr_cnt + wr_p;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   // Verdict and end of run
   task automatic print_verdict();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // Access with target, data and pulse checks
   task automatic run_acc(input logic sty, input logic rd, input logic [11:0] a,
      input logic [15:0] w, input logic [7:0] m);
      int r0;
      int w0;
      r0 = rd_cnt;
      w0 = wr_cnt;
      u_host.access(sty, rd, a, w, 1'b0, rv);
      `CHK("reads", r0 + rd, rd_cnt)
      `CHK("writes", w0 + !rd, wr_cnt)
      `CHK("mask", m, seen.target.framer_mask)
      `CHK("offset", a[7:0], seen.target.offset)
      `CHK("global", a[11] & a[8] & !a[9], seen.target.global_sel)
      if (rd) `CHK("rdata", {8'hA5, a[7:0]}, rv)
      else `CHK("wdata", w, seen.wdata)
   endtask : run_acc
   // Reads of every framer, separate strobes
   task automatic t_reads();
      for (int i = 0; i < 8; i++) run_acc(1'b1, 1'b1, {1'b0, i[2:0], 8'h10 + 8'(i)},
         16'h0000, 8'h01 << i);
   endtask : t_reads
   // Writes in both styles, broadcast, global read
   task automatic t_writes();
      run_acc(1'b0, 1'b0, 12'h534, 16'hBEEF, 8'h20);
      run_acc(1'b1, 1'b0, 12'h356, 16'h1234, 8'h08);
      run_acc(1'b1, 1'b0, 12'h856, 16'hC3C3, 8'hFF);
      run_acc(1'b0, 1'b1, 12'h907, 16'h0000, 8'h00);
   endtask : t_writes
   // Deselected cycle takes nothing
   task automatic t_cs_high();
      int r0;
      r0 = rd_cnt;
      u_host.access(1'b1, 1'b1, 12'h123, 16'h0000, 1'b1, rv);
      `CHK("deselected reads", r0, rd_cnt)
      `CHK("deselected bus", 16'hFFFF, rv)
   endtask : t_cs_high
   // Interrupt raised then released
   task automatic t_irq();
      irq_req <= 8'h10;
      repeat (3) @(posedge clock_i);
      #1 `CHK("irq oe", 1'b1, irq_oe)
      `CHK("irq level", 1'b0, irq_n)
      @(posedge clock_i);
      irq_req <= 8'h00;
      repeat (3) @(posedge clock_i);
      #1 `CHK("irq oe off", 1'b0, irq_oe)
   endtask : t_irq
   // Alarm and reset pins
   task automatic t_pins();
      @(posedge clock_i);
      alarm_n <= 1'b0;
      ext_n <= 1'b0; // Held low seven cycles, 140 ns
      repeat (6) @(posedge clock_i);
      #1 `CHK("alarm", 8'hFF, alarm)
      `CHK("framer reset", 1'b1, frst)
      @(posedge clock_i);
      alarm_n <= 1'b1;
      ext_n <= 1'b1;
      repeat (6) @(posedge clock_i);
      #1 `CHK("alarm off", 8'h00, alarm)
      `CHK("reset off", 1'b0, frst)
   endtask : t_pins
   // Main sequence
   initial begin
      repeat (10) @(posedge clock_i);
      resetn_i <= 1'b1;
      ext_n <= 1'b1; // Raised after power-up
      alarm_n <= 1'b1; // Raised after power-up
      repeat (6) @(posedge clock_i);
      t_reads();
      t_writes();
      t_cs_high();
      t_irq();
      t_pins();
      print_verdict();
   end
endmodule : testbench
